// file: include/lhs_pkg.sv
// Package for the LIN slave header and baud synchroniser.
// Assumes one core clock and a plain strobe register port with 8-bit data.
package lhs_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [2:0] OFF_CTRL = 3'h0;
	localparam logic [2:0] OFF_STATUS = 3'h1;
	localparam logic [2:0] OFF_DATA = 3'h2;
	localparam logic [2:0] OFF_MANT = 3'h3;
	localparam logic [2:0] OFF_FRAC = 3'h4;
	localparam logic [2:0] OFF_HLEN = 3'h5;
	localparam logic [2:0] OFF_PRESC = 3'h6;
	localparam int CTRL_LSF = 0;
	localparam int CTRL_HDM = 1;
	localparam int CTRL_ASE = 2;
	localparam int CTRL_FOL = 3;
	localparam int CTRL_LIN = 4;
	localparam int CTRL_DUM = 5;
	localparam int CTRL_MUTE = 6;
	localparam int ST_FE = 0;
	localparam int ST_HE = 1;
	localparam int ST_RDRF = 2;
	localparam int ST_HDF = 3;
	localparam int ST_BLK = 4;
	localparam logic [11:0] DIV_RST = 12'h100;
	localparam logic [7:0] PRESC_RST = 8'h10;
	localparam logic [5:0] HDR_LIMIT_BITS = 6'h39;
	localparam logic [2:0] SYNC_LAST_EDGE = 3'h4;
	localparam logic [7:0] SYNC_VALUE = 8'h55;
	localparam logic [3:0] OS_LAST = 4'hf;
	localparam logic [3:0] SMP_FIRST = 4'h7;
	localparam logic [3:0] SMP_LAST = 4'h9;
	localparam logic [3:0] BRK_MIN_BITS = 4'hb;
	localparam logic [3:0] CHAR_DOM_BITS = 4'ha;
	localparam logic [12:0] ONE_CLK = 13'h0010;
	typedef struct packed {
		logic mute;
		logic dum;
		logic lin_en;
		logic follower;
		logic ase;
		logic hdm;
	} lhs_ctrl_t;
	typedef struct packed {
		logic vld;
		logic ferr;
		logic brk;
		logic [7:0] data;
	} lhs_char_t;
endpackage

// file: verilog/lhs_rx_sampler.sv
// Oversampling character receiver with break detection.
// Assumes a synchronised receive line, its falling edge and a 16x tick on the same clock.
`timescale 1ns/100ps
module lhs_rx_sampler import lhs_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic os_tick,
	input wire logic rx_s,
	input wire logic rx_fall,
	input wire logic run,
	output lhs_char_t chr
);
	typedef enum logic [2:0] {SM_IDLE, SM_START, SM_DATA, SM_STOP, SM_BREAK} lhs_sm_t;
	lhs_sm_t state_ff;
	logic [3:0] tick_ff;
	logic [2:0] bit_ff;
	logic [2:0] smp_ff;
	logic [7:0] shift_ff;
	logic [3:0] dom_ff;
	logic maj;
	logic bit_end;

	// Bit value is the majority of the 8th, 9th and 10th samples.
	assign maj = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & smp_ff[2]) | (smp_ff[1] & smp_ff[2]);
	assign bit_end = os_tick && tick_ff == OS_LAST;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_ff <= 4'h0;
			smp_ff <= 3'h0;
		end else if (state_ff == SM_IDLE) begin
			tick_ff <= 4'h0; // Phase restarts at each start edge.
		end else if (os_tick) begin
			tick_ff <= tick_ff + 4'h1; // Sixteen samples per bit.
			if (tick_ff >= SMP_FIRST && tick_ff <= SMP_LAST) begin
				smp_ff <= {smp_ff[1:0], rx_s};
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= SM_IDLE;
			bit_ff <= 3'h0;
			shift_ff <= 8'h00;
			dom_ff <= 4'h0;
			chr <= '0;
		end else begin
			chr.vld <= 1'b0;
			chr.brk <= 1'b0;
			if (!run) begin
				state_ff <= SM_IDLE;
			end else begin
				case (state_ff)
					SM_IDLE: begin
						if (rx_fall) begin
							state_ff <= SM_START;
						end
					end
					SM_START: begin
						if (bit_end) begin
							state_ff <= maj ? SM_IDLE : SM_DATA;
							bit_ff <= 3'h0;
						end
					end
					SM_DATA: begin
						if (bit_end) begin
							shift_ff <= {maj, shift_ff[7:1]};
							bit_ff <= bit_ff + 3'h1;
							if (bit_ff == 3'h7) begin
								state_ff <= SM_STOP;
							end
						end
					end
					SM_STOP: begin
						if (bit_end) begin
							if (!maj && shift_ff == 8'h00) begin
								state_ff <= SM_BREAK;
								dom_ff <= CHAR_DOM_BITS;
							end else begin
								state_ff <= SM_IDLE;
								chr.vld <= 1'b1;
								chr.ferr <= ~maj;
								chr.data <= shift_ff;
							end
						end
					end
					SM_BREAK: begin
						if (bit_end) begin
							if (!maj) begin
								dom_ff <= (dom_ff == 4'hf) ? dom_ff : dom_ff + 4'h1;
							end else begin
								// A break is 11 or more dominant bits closed by a recessive bit.
								state_ff <= SM_IDLE;
								chr.data <= 8'h00;
								if (dom_ff >= BRK_MIN_BITS) begin
									chr.brk <= 1'b1;
								end else begin
									chr.vld <= 1'b1;
									chr.ferr <= 1'b1;
								end
							end
						end
					end
					default: begin
						state_ff <= SM_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// file: verilog/lhs_top.sv
// LIN slave header supervision, synch field measurement and baud generation.
// Assumes a receive pin from a LIN transceiver and a strobe register port on core_clk.
// Function
// - Header time is supervised only with identifier detection or auto synch enabled.
// - Header lasting over 57 slave bit times sets the header error flag.
// - Header timeout counter restarts at every detected break.
// - Counter stops on identifier, other header error, or lock bit cleared during synch.
// - Timeout during synch with auto synch blocks the block and keeps lock bit set.
// - Other timeouts discard the header and return to break search.
// - Header length is captured for software whenever supervision is active.
// - In mute with identifier detection, header errors flag without waking; search restarts unless a synch measurement error or timeout blocks.
// - In mute, framing errors on ordinary characters are dropped and not flagged.
// - Identifier detection wakes only on valid break, synch and identifier, in time.
// - Identifier parity never blocks wake-up.
// - Auto synch counts clocks across five falling edges into a 15-bit register.
// - At the fifth edge a measured divider within tolerance of the nominal loads active and readable divider.
// - Character reception is halted while the synch field is measured.
// - Slave mode uses one shared baud of clock over 16 times active divider.
// - Divider is 8-bit mantissa plus 4-bit fraction, unsigned fixed point.
// - Master mode takes its baud from the prescaler instead.
// - Nominal, measured and active divider copies are kept.
// - Simultaneous software and measurement update gives the nominal value with update method clear, the measured value with it set.
// - Each bit is sampled 16 times; samples 8 to 10 decide it.
// - Sampling phase realigns at each start bit.
// - Synch measurement covers eight bit times with clocked counter and edge detect.
// - Update method clear applies mantissa writes at once, set at next character.
// - Header error clears by status read then data read, lock bit first.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
module lhs_top import lhs_pkg::*; (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic rx_data_in,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	output logic baud_tick
);
	typedef enum logic [2:0] {HS_HUNT, HS_MEAS, HS_SYNCCHR, HS_IDCHR, HS_BLOCKED} lhs_hs_t;
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [2:0] rx_sync_ff;
	logic rx_s;
	logic rx_fall;
	lhs_ctrl_t ctrl_ff;
	logic sync_field_lock_bit_ff;
	logic header_error_flag_ff;
	logic framing_error_flag_ff;
	logic rdrf_ff;
	logic hdf_ff;
	logic [7:0] data_ff;
	logic [7:0] presc_ff;
	logic [11:0] nominal_divider_ff;
	logic [11:0] active_divider_ff;
	logic [11:0] measured_divider;
	logic [7:0] header_length_reg_ff;
	logic stat_seen_ff;
	logic [12:0] acc_ff;
	logic [12:0] acc_sum;
	logic [11:0] div_sel;
	logic [3:0] os_cnt_ff;
	logic bit_tick;
	lhs_hs_t hs_ff;
	logic hdr_run_ff;
	logic [5:0] hdr_cnt_ff;
	logic [2:0] edge_ff;
	logic [14:0] sync_measure_count_ff;
	logic meas_ovf_ff;
	lhs_char_t chr;
	logic slave;
	logic sup;
	logic samp_run;
	logic wr_ctrl;
	logic wr_mant;
	logic lsf_sw_clr;
	logic clr_seq;
	logic tmo;
	logic meas_done;
	logic meas_bad;
	logic meas_load;
	logic [11:0] dev;
	logic [11:0] tol;
	logic hdr_err;
	logic hdr_stop;
	logic id_ok;
	logic xfer;
	logic fe_set;
	logic wake;
	logic pend_ff;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sync_ff <= 3'b111;
		end else begin
			rx_sync_ff <= {rx_sync_ff[1:0], rx_data_in};
		end
	end
	assign rx_s = rx_sync_ff[1];
	assign rx_fall = rx_sync_ff[2] & ~rx_sync_ff[1]; // Edge detect on the core clock.

	assign slave = ctrl_ff.lin_en & ctrl_ff.follower;
	assign sup = slave & (ctrl_ff.hdm | ctrl_ff.ase);
	assign wr_ctrl = reg_wr && reg_addr == OFF_CTRL;
	assign wr_mant = reg_wr && reg_addr == OFF_MANT;
	assign lsf_sw_clr = wr_ctrl && !reg_wdata[CTRL_LSF] && sync_field_lock_bit_ff;
	assign clr_seq = reg_rd && reg_addr == OFF_DATA && stat_seen_ff;

	// Slave mode divides by the active divider, master mode by the prescaler.
	assign div_sel = slave ? active_divider_ff : {presc_ff, 4'h0};
	assign acc_sum = acc_ff + ONE_CLK;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff <= 13'h0000;
			baud_tick <= 1'b0;
		end else if (acc_sum >= {1'b0, div_sel}) begin
			// Fraction has 4 bits, so one clock adds 16 to the accumulator.
			acc_ff <= acc_sum - {1'b0, div_sel};
			baud_tick <= 1'b1;
		end else begin
			acc_ff <= acc_sum;
			baud_tick <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			os_cnt_ff <= 4'h0;
		end else if (baud_tick) begin
			os_cnt_ff <= os_cnt_ff + 4'h1;
		end
	end
	assign bit_tick = baud_tick && os_cnt_ff == OS_LAST;

	// Receiver is halted during measurement and while blocked.
	assign samp_run = !(slave && (hs_ff == HS_MEAS || hs_ff == HS_BLOCKED));
	lhs_rx_sampler u_sampler (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.os_tick(baud_tick),
		.rx_s(rx_s),
		.rx_fall(rx_fall),
		.run(samp_run),
		.chr(chr)
	);

	assign tmo = hdr_run_ff && sup && bit_tick && hdr_cnt_ff == HDR_LIMIT_BITS;
	assign measured_divider = sync_measure_count_ff[14:3]; // Eight bits of 16 ticks each.
	assign dev = (measured_divider > nominal_divider_ff) ? measured_divider - nominal_divider_ff :
		nominal_divider_ff - measured_divider;
	assign tol = {3'h0, nominal_divider_ff[11:3]} + {5'h00, nominal_divider_ff[11:5]};
	assign meas_done = hs_ff == HS_MEAS && rx_fall && edge_ff == SYNC_LAST_EDGE && !tmo;
	assign meas_bad = meas_ovf_ff || dev > tol;
	assign meas_load = meas_done && !meas_bad;
	assign id_ok = hs_ff == HS_IDCHR && chr.vld && !chr.ferr; // Parity plays no part.
	assign hdr_err = (meas_done && meas_bad) ||
		(hs_ff == HS_SYNCCHR && chr.vld && (chr.ferr || chr.data != SYNC_VALUE)) ||
		(hs_ff == HS_IDCHR && chr.vld && chr.ferr);
	assign hdr_stop = id_ok || hdr_err || (lsf_sw_clr && hs_ff == HS_MEAS);
	assign wake = slave && ((chr.brk && !ctrl_ff.hdm) || (id_ok && ctrl_ff.hdm));
	assign xfer = slave ? ((chr.brk && !ctrl_ff.hdm) || (id_ok && ctrl_ff.hdm) ||
		(hs_ff == HS_HUNT && chr.vld && !ctrl_ff.mute) ||
		(hs_ff == HS_SYNCCHR && chr.vld && !ctrl_ff.mute && !ctrl_ff.hdm && !hdr_err) ||
		(hs_ff == HS_IDCHR && chr.vld && !ctrl_ff.mute && !ctrl_ff.hdm)) :
		(chr.vld && !ctrl_ff.mute);
	assign fe_set = chr.vld && chr.ferr && !ctrl_ff.mute;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hs_ff <= HS_HUNT;
		end else if (!slave) begin
			hs_ff <= HS_HUNT;
		end else begin
			case (hs_ff)
				HS_BLOCKED: begin
					if (lsf_sw_clr) begin
						hs_ff <= HS_HUNT;
					end
				end
				HS_MEAS: begin
					if (tmo && ctrl_ff.ase) begin
						hs_ff <= HS_BLOCKED;
					end else if (lsf_sw_clr) begin
						hs_ff <= HS_HUNT;
					end else if (meas_done) begin
						hs_ff <= meas_bad ? HS_BLOCKED : HS_IDCHR;
					end
				end
				default: begin
					if (chr.brk) begin
						hs_ff <= ctrl_ff.ase ? HS_MEAS : HS_SYNCCHR;
					end else if (tmo || hdr_err || id_ok) begin
						hs_ff <= HS_HUNT; // Header discarded, break search resumes.
					end else if (hs_ff == HS_SYNCCHR && chr.vld) begin
						hs_ff <= HS_IDCHR;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hdr_run_ff <= 1'b0;
			hdr_cnt_ff <= 6'h00;
			header_length_reg_ff <= 8'h00;
		end else begin
			if (slave && chr.brk && hs_ff != HS_BLOCKED) begin
				hdr_run_ff <= 1'b1;
				hdr_cnt_ff <= 6'h00;
			end else if (tmo || hdr_stop) begin
				hdr_run_ff <= 1'b0;
				if (sup) begin
					header_length_reg_ff <= {2'b00, hdr_cnt_ff} + {7'h00, tmo};
				end
			end else if (hdr_run_ff && bit_tick) begin
				hdr_cnt_ff <= hdr_cnt_ff + 6'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_ff <= 3'h0;
			sync_measure_count_ff <= 15'h0000;
			meas_ovf_ff <= 1'b0;
		end else if (hs_ff != HS_MEAS) begin
			edge_ff <= 3'h0;
			meas_ovf_ff <= 1'b0;
		end else begin
			if (rx_fall) begin
				edge_ff <= edge_ff + 3'h1;
			end
			if (rx_fall && edge_ff == 3'h0) begin
				// The first edge cycle counts, so the span covers every cycle up to the fifth edge.
				sync_measure_count_ff <= 15'h0001;
			end else if (edge_ff != 3'h0 && !meas_done) begin
				if (sync_measure_count_ff == 15'h7fff) begin
					meas_ovf_ff <= 1'b1;
				end else begin
					sync_measure_count_ff <= sync_measure_count_ff + 15'h0001;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nominal_divider_ff <= DIV_RST;
			active_divider_ff <= DIV_RST;
			pend_ff <= 1'b0;
			presc_ff <= PRESC_RST;
		end else begin
			if (reg_wr && reg_addr == OFF_FRAC) begin
				nominal_divider_ff[3:0] <= reg_wdata[3:0];
			end
			if (wr_mant) begin
				nominal_divider_ff[11:4] <= reg_wdata;
			end
			if (reg_wr && reg_addr == OFF_PRESC) begin
				presc_ff <= reg_wdata;
			end
			if (wr_mant && ctrl_ff.dum) begin
				pend_ff <= 1'b1;
			end else if (xfer || !ctrl_ff.dum) begin
				pend_ff <= 1'b0;
			end
			// Software value wins over a same-cycle measurement only with the update method bit clear.
			if (wr_mant && !ctrl_ff.dum) begin
				active_divider_ff <= {reg_wdata, nominal_divider_ff[3:0]};
			end else if (xfer && pend_ff) begin
				active_divider_ff <= nominal_divider_ff;
			end else if (meas_load && ctrl_ff.ase) begin
				active_divider_ff <= measured_divider;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff.hdm <= reg_wdata[CTRL_HDM];
				ctrl_ff.ase <= reg_wdata[CTRL_ASE];
				ctrl_ff.follower <= reg_wdata[CTRL_FOL];
				ctrl_ff.lin_en <= reg_wdata[CTRL_LIN];
			end
			if (xfer && slave) begin
				ctrl_ff.dum <= 1'b0;
			end else if (wr_ctrl) begin
				ctrl_ff.dum <= reg_wdata[CTRL_DUM];
			end
			if (wake) begin
				ctrl_ff.mute <= 1'b0; // Header errors never reach here.
			end else if (wr_ctrl) begin
				ctrl_ff.mute <= reg_wdata[CTRL_MUTE];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_field_lock_bit_ff <= 1'b0;
		end else if ((slave && chr.brk && ctrl_ff.ase && hs_ff != HS_BLOCKED) || (tmo && hs_ff == HS_MEAS)) begin
			sync_field_lock_bit_ff <= 1'b1;
		end else if (meas_load || lsf_sw_clr) begin
			sync_field_lock_bit_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			header_error_flag_ff <= 1'b0;
			framing_error_flag_ff <= 1'b0;
			rdrf_ff <= 1'b0;
			hdf_ff <= 1'b0;
			data_ff <= 8'h00;
			stat_seen_ff <= 1'b0;
		end else begin
			if (tmo || hdr_err) begin
				header_error_flag_ff <= 1'b1;
			end else if (clr_seq && !sync_field_lock_bit_ff) begin
				header_error_flag_ff <= 1'b0;
			end
			if (fe_set) begin
				framing_error_flag_ff <= 1'b1;
			end else if (clr_seq) begin
				framing_error_flag_ff <= 1'b0;
			end
			if (xfer) begin
				rdrf_ff <= 1'b1;
				data_ff <= chr.data;
			end else if (reg_rd && reg_addr == OFF_DATA) begin
				rdrf_ff <= 1'b0;
			end
			if (wake) begin
				hdf_ff <= 1'b1;
			end else if (wr_ctrl) begin
				hdf_ff <= 1'b0;
			end
			if (reg_rd && reg_addr == OFF_STATUS) begin
				stat_seen_ff <= 1'b1;
			end else if (reg_rd && reg_addr == OFF_DATA) begin
				stat_seen_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == OFF_CTRL) begin
				reg_rdata <= {1'b0, ctrl_ff.mute, ctrl_ff.dum, ctrl_ff.lin_en, ctrl_ff.follower,
					ctrl_ff.ase, ctrl_ff.hdm, sync_field_lock_bit_ff};
			end else if (reg_addr == OFF_STATUS) begin
				reg_rdata <= {3'h0, hs_ff == HS_BLOCKED, hdf_ff, rdrf_ff, header_error_flag_ff,
					framing_error_flag_ff};
			end else if (reg_addr == OFF_DATA) begin
				reg_rdata <= data_ff;
			end else if (reg_addr == OFF_MANT) begin
				reg_rdata <= active_divider_ff[11:4];
			end else if (reg_addr == OFF_FRAC) begin
				reg_rdata <= {4'h0, active_divider_ff[3:0]};
			end else if (reg_addr == OFF_HLEN) begin
				reg_rdata <= header_length_reg_ff;
			end else if (reg_addr == OFF_PRESC) begin
				reg_rdata <= presc_ff;
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule

// file: dv/lhs_top_sva.sv
// Port checker for the LIN slave header block.
// Assumes the single core_clk domain and the strobe register port of the package.
`timescale 1ns/100ps
module lhs_top_sva import lhs_pkg::*; (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic rx_data_in,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic baud_tick
);
	logic [DATA_W-1:0] ctrl_sh_ff;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Shadow of the last control write, used to qualify divider readback.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_sh_ff <= 8'h00;
		end else if (reg_wr && reg_addr == OFF_CTRL) begin
			ctrl_sh_ff <= reg_wdata;
		end
	end
	sequence mant_wr_rd_s;
		reg_wr && reg_addr == OFF_MANT && !ctrl_sh_ff[CTRL_DUM] && !ctrl_sh_ff[CTRL_ASE] ##1
		reg_rd && reg_addr == OFF_MANT;
	endsequence
	sequence ctrl_wr_rd_s;
		reg_wr && reg_addr == OFF_CTRL ##1 reg_rd && reg_addr == OFF_CTRL;
	endsequence
	sequence lock_clr_rd_s;
		reg_wr && reg_addr == OFF_CTRL && !reg_wdata[CTRL_LSF] ##1 reg_rd && reg_addr == OFF_CTRL;
	endsequence
	sequence blk_then_ctrl_s;
		reg_rd && reg_addr == OFF_STATUS ##1 reg_rdata[ST_BLK] && reg_rd && reg_addr == OFF_CTRL;
	endsequence
	sequence clear_seq_s;
		reg_rd && reg_addr == OFF_STATUS ##1 reg_rd && reg_addr == OFF_DATA ##1 reg_rd && reg_addr == OFF_STATUS;
	endsequence
	unmapped_read_a: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
		else $error("unmapped read returned nonzero");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	mant_readback_a: assert property (mant_wr_rd_s |=> reg_rdata == $past(reg_wdata, 2))
		else $error("mantissa write not applied at once");
	frac_width_a: assert property (reg_rd && reg_addr == OFF_FRAC |=> reg_rdata[7:4] == 4'h0)
		else $error("fraction wider than four bits");
	ctrl_readback_a: assert property (ctrl_wr_rd_s |=> reg_rdata[4:1] == $past(reg_wdata[4:1], 2))
		else $error("mode selection not held");
	lock_clear_a: assert property (lock_clr_rd_s |=> !reg_rdata[CTRL_LSF])
		else $error("lock bit not cleared by software");
	blocked_lock_a: assert property (blk_then_ctrl_s |=> reg_rdata[CTRL_LSF])
		else $error("blocked without lock bit");
	fe_clear_a: assert property (clear_seq_s |=> !reg_rdata[ST_FE])
		else $error("framing flag survived clear sequence");
	hlen_bound_a: assert property (reg_rd && reg_addr == OFF_HLEN |=> reg_rdata <= 8'h3a)
		else $error("header length beyond timeout count");
endmodule
bind lhs_top lhs_top_sva u_sva (.core_clk(core_clk), .nrst(nrst), .rx_data_in(rx_data_in),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .baud_tick(baud_tick));

// file: dv/lhs_lin_master.sv
// Behavioural LIN master node seen through its transceiver on the receive pin.
// Assumes tasks are called just after a rising edge; the bus idles recessive by pull-up.
`timescale 1ns/100ps
module lhs_lin_master (
	input wire logic core_clk,
	output logic rx_line
);
	int bit_cyc = 32;
	initial begin
		rx_line = 1'b1;
	end
	task automatic hold(input logic v, input int nbits);
		rx_line <= v;
		repeat (nbits * bit_cyc) @(posedge core_clk);
	endtask
	task automatic send_char(input logic [7:0] d, input logic stop);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) begin
			hold(d[i], 1);
		end
		hold(stop, 1);
	endtask
	task automatic send_break();
		hold(1'b0, 13);
		// Two recessive bits let the slave close its break before the first synch edge.
		hold(1'b1, 2);
	endtask
	task automatic send_header(input logic [7:0] sync, input logic [7:0] id);
		send_break();
		send_char(sync, 1'b1);
		send_char(id, 1'b1);
	endtask
endmodule

// file: dv/lhs_top_bench.sv
// Self-checking bench for the LIN slave header block.
// Assumes the master model owns the receive pin and the bench owns the register port.
`timescale 1ns/100ps
module lhs_top_bench import lhs_pkg::*; ;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic rx_data_in;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic baud_tick;
	logic [DATA_W-1:0] ans;
	int n_fail = 0;
	int checked = 0;
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	lhs_top dut (.core_clk(core_clk), .nrst(nrst), .rx_data_in(rx_data_in), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .baud_tick(baud_tick));
	lhs_lin_master master (.core_clk(core_clk), .rx_line(rx_data_in));
	// Issues one strobe; ans then holds the answer of the access before it.
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= ~w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		ans = reg_rdata;
	endtask
	task automatic idle();
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge core_clk);
		ans = reg_rdata;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		idle();
		chk(what, exp, ans);
	endtask
	task automatic cfg(input logic [7:0] v);
		acc(1'b1, OFF_CTRL, v);
		acc(1'b0, OFF_CTRL, 8'h00);
		idle();
		chk("ctrl", v, ans);
	endtask
	task automatic set_mant();
		acc(1'b1, OFF_MANT, 8'h02);
		acc(1'b0, OFF_MANT, 8'h00);
		idle();
		chk("mantissa", 8'h02, ans);
	endtask
	task automatic clr_seq(input logic [7:0] s0, input logic dchk, input logic [7:0] d, input logic [7:0] s1);
		acc(1'b0, OFF_STATUS, 8'h00);
		acc(1'b0, OFF_DATA, 8'h00);
		chk("status before clear", s0, ans);
		acc(1'b0, OFF_STATUS, 8'h00);
		if (dchk) begin
			chk("data", d, ans);
		end
		idle();
		chk("status after clear", s1, ans);
	endtask
	task automatic count_ticks(input int cyc, output int n);
		n = 0;
		// Lets the accumulator drain after a divider change before counting.
		repeat (24) @(posedge core_clk);
		repeat (cyc) begin
			@(posedge core_clk);
			if (baud_tick === 1'b1) begin
				n++;
			end
		end
	endtask
	task automatic t_reset();
		logic [2:0] a[6] = '{OFF_CTRL, OFF_STATUS, OFF_MANT, OFF_FRAC, OFF_HLEN, 3'h7};
		logic [7:0] e[6] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
		acc(1'b1, 3'h7, 8'hff);
		acc(1'b1, OFF_STATUS, 8'hff);
		idle();
		for (int i = 0; i < 6; i++) begin
			rd_chk("reset value", a[i], e[i]);
		end
	endtask
	task automatic t_baud();
		int n;
		cfg(8'h18);
		acc(1'b1, OFF_FRAC, 8'h00);
		set_mant();
		count_ticks(64, n);
		chk("slave ticks", 8'h20, n[7:0]);
		cfg(8'h10);
		acc(1'b1, OFF_PRESC, 8'h03);
		idle();
		count_ticks(66, n);
		chk("master ticks", 8'h16, n[7:0]);
	endtask
	task automatic t_sync();
		cfg(8'h5e);
		master.bit_cyc = 36;
		master.send_header(8'h55, 8'hc1);
		master.hold(1'b1, 4);
		rd_chk("measured mantissa", OFF_MANT, 8'h02);
		rd_chk("measured fraction", OFF_FRAC, 8'h04);
		rd_chk("ctrl after wake", OFF_CTRL, 8'h1e);
		clr_seq(8'h0c, 1'b1, 8'hc1, 8'h08);
		master.bit_cyc = 32;
		cfg(8'h18);
		set_mant();
	endtask
	task automatic t_timeout();
		cfg(8'h5a);
		master.send_break();
		master.hold(1'b1, 70);
		rd_chk("header length", OFF_HLEN, 8'h3a);
		rd_chk("ctrl still mute", OFF_CTRL, 8'h5a);
		clr_seq(8'h02, 1'b0, 8'h00, 8'h00);
		cfg(8'h18);
		master.send_break();
		master.hold(1'b1, 70);
		clr_seq(8'h0c, 1'b1, 8'h00, 8'h08);
	endtask
	task automatic t_block();
		cfg(8'h1e);
		master.send_break();
		master.hold(1'b1, 70);
		acc(1'b0, OFF_STATUS, 8'h00);
		acc(1'b0, OFF_CTRL, 8'h00);
		idle();
		chk("ctrl when blocked", 8'h1f, ans);
		clr_seq(8'h12, 1'b0, 8'h00, 8'h12);
		cfg(8'h1e);
		clr_seq(8'h02, 1'b0, 8'h00, 8'h00);
	endtask
	task automatic t_fe();
		cfg(8'h5a);
		master.send_char(8'h0f, 1'b0);
		master.hold(1'b1, 2);
		rd_chk("status in mute", OFF_STATUS, 8'h00);
		cfg(8'h1a);
		master.send_char(8'h0f, 1'b0);
		master.hold(1'b1, 2);
		acc(1'b0, OFF_STATUS, 8'h00);
		idle();
		chk("framing flag", 8'h01, ans & 8'h01);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_baud();
		t_sync();
		t_timeout();
		t_block();
		t_fe();
		summarize();
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		summarize();
	end
endmodule
